/* common/tcp_params.svh */
`ifndef TCP_PARAMS_SVH
`define TCP_PARAMS_SVH
// peripheral file addresses
`define TCP_SETUP_ADDR 16'h1040
`define TCP_CDSTART_ADDR 16'h1041
`define TCP_CDEND_ADDR 16'h1042
`define TCP_BUFPTR_ADDR 16'h1043
`define TCP_CAPEN_ADDR 16'h104D
`define TCP_GLOBAL_ADDR 16'h104F
// shared ram window
`define TCP_RAM_LO_BASE 16'h0080
`define TCP_RAM_HI_BASE 16'h0180
`define TCP_RAM_MASK 16'hFF80
`define TCP_REG_RST 8'h00
// field positions
`define TCP_PS_MSB 3
`define TCP_FAST_BIT 4
`define TCP_CMDEN_BIT 5
`define TCP_MODEB_BIT 0
`define TCP_START_MSB 3
`define TCP_START_HI 1'b1
`define TCP_END_MSB 4
`define TCP_PTR_MSB 6
`define TCP_PTR_LSB 2
// prescaler
`define TCP_PS_ZERO 4'h0
`define TCP_PS_ZERO_LAST 4'h1
`define TCP_DIV8_LAST 3'h7
// ram word map, highest word first
`define TCP_IMG_WORD 5'h1F
`define TCP_DED_TOP 5'h1E
`define TCP_BUF_TOP_A 5'h1C
`define TCP_BUF_TOP_B 5'h1A
`define TCP_NDED_A 3'h2
`define TCP_NDED_B 3'h4
// command entry fields
`define TCP_OP_MSB 31
`define TCP_OP_LSB 28
`define TCP_OP_CMP 4'h1
`define TCP_OP_HALVE 4'hF
`define TCP_CMP_MSB 15
`define TCP_SEL_MSB 18
`define TCP_SEL_LSB 16
`define TCP_ACT_BIT 19
`define TCP_HALVE_GAP 6'h02
`define TCP_NCAP 6
`endif

/* common/tcp_pkg.sv */
package tcp_pkg;
    typedef enum logic [1:0] {
        TCP_SEQ_IDLE = 2'b00,
        TCP_SEQ_FETCH = 2'b01,
        TCP_SEQ_EXEC = 2'b10
    } tcp_seq_e;
    typedef logic [4:0] tcp_word_t;
    typedef logic [31:0] tcp_entry_t;
endpackage

/* hdl/tcp_dpram.sv */
`timescale 1ns/1ps
module tcp_dpram (
    // clock
    input wire logic sys_clk,
    // cpu byte port
    input wire logic [6:0] a_addr,
    input wire logic a_we,
    input wire logic [7:0] a_wdata,
    output logic [7:0] a_rdata,
    // coprocessor word port
    input wire tcp_pkg::tcp_word_t b_waddr,
    input wire logic b_we,
    input wire tcp_pkg::tcp_entry_t b_wdata,
    input wire tcp_pkg::tcp_word_t b_raddr,
    output tcp_pkg::tcp_entry_t b_rdata
);
    logic [31:0] b_rd_w;
    logic [31:0] a_word_w;
    logic [1:0] a_sel;
    // lane 0 is the lowest byte address and carries the top byte of a word
    genvar k;
    for (k = 0; k < 4; k++) begin : g_lane
        logic [7:0] mem [0:31]; // 128 bytes in four lanes
        always_ff @(posedge sys_clk) begin
            if (b_we) begin
                mem[b_waddr] <= b_wdata[31-8*k -: 8];
            end
            // a coprocessor update of the same word wins over the cpu byte
            if (a_we && a_addr[1:0] == 2'(k) && !(b_we && b_waddr == a_addr[6:2])) begin
                mem[a_addr[6:2]] <= a_wdata;
            end
        end
        assign b_rd_w[31-8*k -: 8] = mem[b_raddr];
        assign a_word_w[31-8*k -: 8] = mem[a_addr[6:2]];
    end
    assign a_sel = 2'h3 - a_addr[1:0];
    always_ff @(posedge sys_clk) begin
        b_rdata <= b_rd_w;
        a_rdata <= a_word_w[{a_sel, 3'b000} +: 8];
    end
endmodule

/* hdl/tcp_top.sv */
`timescale 1ns/1ps
`include "tcp_params.svh"
// Summary of operation
// - mode A: inputs 1-2 dedicated, 3-6 buffered; mode B: 1-4 dedicated; input 6 counts events
// - reset drives all eight timed outputs low
// - system clock feeds 4-bit prescaler, optional divide-by-8, then 20-bit counter
// - divide is prescale plus one, zero gives two; slow mode multiplies by eight
// - prescale and fast-mode bits sit in the setup control register at 1040h
// - command entries are 32 bits, run in order from entry zero beside buffer
// - a halving entry makes entries two after it onward run at half rate
// - halving hits every operation from two entries after it on; only full and half rates exist
// - 128-byte shared ram sits at 0080h or 0180h, reachable by cpu and coprocessor
// - command start is a 4-bit word field, end a 5-bit word field
// - circular buffer spans from below the dedicated slots down to the command start
// - each buffered capture fills the next buffer word, wrapping over the oldest
// - dedicated capture words are written when enabled; cpu may read and write them
// - timer and event images in the top word are rewritten every prescaled tick
// - top word holds 20-bit timer, flags of inputs 3-6 and 8-bit event count
// - two dedicated slots in mode A, four in mode B, buffer below them
// - capture word: timer bits 19-0, pin id 23-20 (one-hot for inputs 3-6, zero for 1-2), event count on top
// - each tick increments the counter and restarts the command sequencer
module tcp_top #(
    parameter bit RAM_AT_HI = 1'b0
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // cpu access
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    output logic cpu_rvalid,
    // capture pins
    input wire logic capture_in_1,
    input wire logic capture_in_2,
    input wire logic capture_in_3,
    input wire logic capture_in_4,
    input wire logic capture_in_5,
    input wire logic capture_in_6_event,
    // timed outputs
    output logic [7:0] timed_outputs
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] setup_ff, cdstart_ff, cdend_ff, capen_ff, global_ff;
    logic [4:0] bufptr_ff;
    logic [3:0] ps, last_w, pre_cnt_ff;
    logic [2:0] div8_ff, nded;
    logic fast, cmd_en, mode_b, pre_wrap, tick_ff, par_ff;
    logic [19:0] timer_ff;
    logic [7:0] evt_ff, reg_rd_w, reg_hold_ff, rdata_ff, outs_ff;
    logic [3:0] flags_ff;
    tcp_pkg::tcp_word_t start_idx, end_idx, buf_top, buf_bot;
    logic [15:0] ram_base;
    logic ram_sel, rd1_ff, rd1_ram_ff, rvalid_ff;
    logic [5:0] pins_w, rise_w, ded_w, pend_w, serve_w;
    logic [31:0] val_w [0:5];
    logic img_pend_ff, b_we, buf_wr_w;
    tcp_pkg::tcp_word_t b_waddr, cur_ff;
    tcp_pkg::tcp_entry_t b_wdata, entry;
    logic [7:0] a_rdata;
    tcp_pkg::tcp_seq_e seq_ff;
    logic [4:0] n_ff;
    logic [5:0] half_pos_ff;
    logic half_on_ff, skip_w;
    logic [3:0] op_w;

    assign ps = setup_ff[`TCP_PS_MSB:0];
    assign fast = setup_ff[`TCP_FAST_BIT];
    assign cmd_en = setup_ff[`TCP_CMDEN_BIT];
    assign mode_b = global_ff[`TCP_MODEB_BIT];
    assign start_idx = {`TCP_START_HI, cdstart_ff[`TCP_START_MSB:0]};
    assign end_idx = cdend_ff[`TCP_END_MSB:0];
    assign nded = mode_b ? `TCP_NDED_B : `TCP_NDED_A;
    assign buf_top = mode_b ? `TCP_BUF_TOP_B : `TCP_BUF_TOP_A;
    assign buf_bot = start_idx + 5'h01;

    ////////////////////////////////////////////////////////////////////////////////
    // time base
    assign last_w = (ps == `TCP_PS_ZERO) ? `TCP_PS_ZERO_LAST : ps;
    // >= rather than == so a smaller prescale written mid-count cannot stall
    assign pre_wrap = pre_cnt_ff >= last_w;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt_ff <= 4'h0;
            div8_ff <= 3'h0;
            tick_ff <= 1'b0;
        end else begin
            pre_cnt_ff <= pre_wrap ? 4'h0 : pre_cnt_ff + 4'h1;
            if (pre_wrap) begin
                div8_ff <= div8_ff + 3'h1;
            end
            tick_ff <= pre_wrap && (fast || div8_ff == `TCP_DIV8_LAST);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_ff <= 20'h0_0000;
            par_ff <= 1'b0;
        end else if (tick_ff) begin
            timer_ff <= timer_ff + 20'h0_0001;
            par_ff <= !par_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register access
    assign ram_base = RAM_AT_HI ? `TCP_RAM_HI_BASE : `TCP_RAM_LO_BASE;
    assign ram_sel = (cpu_addr & `TCP_RAM_MASK) == ram_base;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            setup_ff <= `TCP_REG_RST;
            cdstart_ff <= `TCP_REG_RST;
            cdend_ff <= `TCP_REG_RST;
            capen_ff <= `TCP_REG_RST;
            global_ff <= `TCP_REG_RST;
        end else if (cpu_wr) begin
            if (cpu_addr == `TCP_SETUP_ADDR) begin
                setup_ff <= cpu_wdata;
            end else if (cpu_addr == `TCP_CDSTART_ADDR) begin
                cdstart_ff <= cpu_wdata;
            end else if (cpu_addr == `TCP_CDEND_ADDR) begin
                cdend_ff <= cpu_wdata;
            end else if (cpu_addr == `TCP_CAPEN_ADDR) begin
                capen_ff <= cpu_wdata;
            end else if (cpu_addr == `TCP_GLOBAL_ADDR) begin
                global_ff <= cpu_wdata;
            end
        end
    end

    always_comb begin
        if (cpu_addr == `TCP_SETUP_ADDR) begin
            reg_rd_w = setup_ff;
        end else if (cpu_addr == `TCP_CDSTART_ADDR) begin
            reg_rd_w = cdstart_ff;
        end else if (cpu_addr == `TCP_CDEND_ADDR) begin
            reg_rd_w = cdend_ff;
        end else if (cpu_addr == `TCP_BUFPTR_ADDR) begin
            reg_rd_w = {1'b0, bufptr_ff, 2'b00};
        end else if (cpu_addr == `TCP_CAPEN_ADDR) begin
            reg_rd_w = capen_ff;
        end else if (cpu_addr == `TCP_GLOBAL_ADDR) begin
            reg_rd_w = global_ff;
        end else begin
            reg_rd_w = 8'h00;
        end
    end

    // two-stage read so ram and registers answer with the same latency
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd1_ff <= 1'b0;
            rd1_ram_ff <= 1'b0;
            reg_hold_ff <= 8'h00;
            rdata_ff <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rd1_ff <= cpu_rd;
            rd1_ram_ff <= ram_sel;
            reg_hold_ff <= reg_rd_w;
            rvalid_ff <= rd1_ff;
            if (rd1_ff) begin
                rdata_ff <= rd1_ram_ff ? a_rdata : reg_hold_ff;
            end
        end
    end
    assign cpu_rdata = rdata_ff;
    assign cpu_rvalid = rvalid_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // capture inputs
    assign pins_w = {capture_in_6_event, capture_in_5, capture_in_4, capture_in_3, capture_in_2, capture_in_1};

    genvar i;
    for (i = 0; i < `TCP_NCAP; i++) begin : g_cap
        localparam logic [3:0] PID = (i >= 2) ? 4'(1 << (i - 2)) : 4'h0;
        logic [2:0] sy_ff;
        logic lvl_ff, pend_ff;
        logic [31:0] val_ff;
        assign rise_w[i] = (sy_ff[1] == sy_ff[2]) && sy_ff[2] && !lvl_ff;
        assign ded_w[i] = 3'(i) < nded;
        assign pend_w[i] = pend_ff;
        assign val_w[i] = val_ff;
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                sy_ff <= 3'h0;
                lvl_ff <= 1'b0;
                pend_ff <= 1'b0;
                val_ff <= 32'h0000_0000;
            end else begin
                sy_ff <= {sy_ff[1:0], pins_w[i]};
                if (sy_ff[1] == sy_ff[2]) begin
                    lvl_ff <= sy_ff[2];
                end
                // a new request beats the clear of the one being written
                if (rise_w[i] && capen_ff[i]) begin
                    pend_ff <= 1'b1;
                    val_ff <= {evt_ff, PID, timer_ff};
                end else if (serve_w[i]) begin
                    pend_ff <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_ff <= 8'h00;
            flags_ff <= 4'h0;
            img_pend_ff <= 1'b0;
        end else begin
            if (rise_w[`TCP_NCAP-1]) begin
                evt_ff <= evt_ff + 8'h01;
            end
            flags_ff <= (img_pend_ff ? 4'h0 : flags_ff) | (rise_w[5:2] & capen_ff[5:2]);
            img_pend_ff <= tick_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // coprocessor write port: image first, then lowest pending capture
    always_comb begin
        serve_w = 6'h00;
        buf_wr_w = 1'b0;
        b_we = img_pend_ff;
        b_waddr = `TCP_IMG_WORD;
        b_wdata = {evt_ff, flags_ff, timer_ff};
        for (int j = 0; j < `TCP_NCAP; j++) begin
            if (!img_pend_ff && !b_we && pend_w[j]) begin
                serve_w[j] = 1'b1;
                b_we = 1'b1;
                b_wdata = val_w[j];
                if (ded_w[j]) begin
                    b_waddr = `TCP_DED_TOP - 5'(j);
                end else begin
                    b_waddr = bufptr_ff;
                    buf_wr_w = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bufptr_ff <= `TCP_BUF_TOP_A;
        end else if (buf_wr_w) begin
            bufptr_ff <= (bufptr_ff <= buf_bot) ? buf_top : bufptr_ff - 5'h01;
        end else if (cpu_wr && cpu_addr == `TCP_BUFPTR_ADDR) begin
            bufptr_ff <= cpu_wdata[`TCP_PTR_MSB:`TCP_PTR_LSB];
        end
    end

    tcp_dpram u_ram (
        .sys_clk(sys_clk),
        .a_addr(cpu_addr[6:0]),
        .a_we(cpu_wr && ram_sel),
        .a_wdata(cpu_wdata),
        .a_rdata(a_rdata),
        .b_waddr(b_waddr),
        .b_we(b_we),
        .b_wdata(b_wdata),
        .b_raddr(cur_ff),
        .b_rdata(entry)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // command sequencer
    assign op_w = entry[`TCP_OP_MSB:`TCP_OP_LSB];
    assign skip_w = half_on_ff && ({1'b0, n_ff} >= half_pos_ff) && par_ff;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_ff <= tcp_pkg::TCP_SEQ_IDLE;
            cur_ff <= 5'h00;
            n_ff <= 5'h00;
            half_on_ff <= 1'b0;
            half_pos_ff <= 6'h00;
        end else if (tick_ff) begin
            // an overrunning pass is cut short by the next tick
            seq_ff <= cmd_en ? tcp_pkg::TCP_SEQ_FETCH : tcp_pkg::TCP_SEQ_IDLE;
            cur_ff <= start_idx;
            n_ff <= 5'h00;
            half_on_ff <= 1'b0;
        end else begin
            case (seq_ff)
                tcp_pkg::TCP_SEQ_FETCH: begin
                    seq_ff <= skip_w ? tcp_pkg::TCP_SEQ_IDLE : tcp_pkg::TCP_SEQ_EXEC;
                end
                tcp_pkg::TCP_SEQ_EXEC: begin
                    // only the first halving counts: no slower than half rate
                    if (op_w == `TCP_OP_HALVE && !half_on_ff) begin
                        half_on_ff <= 1'b1;
                        half_pos_ff <= {1'b0, n_ff} + `TCP_HALVE_GAP;
                    end
                    if (cur_ff == end_idx || cur_ff == 5'h00) begin
                        seq_ff <= tcp_pkg::TCP_SEQ_IDLE;
                    end else begin
                        cur_ff <= cur_ff - 5'h01;
                        n_ff <= n_ff + 5'h01;
                        seq_ff <= tcp_pkg::TCP_SEQ_FETCH;
                    end
                end
                default: begin
                    seq_ff <= tcp_pkg::TCP_SEQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            outs_ff <= 8'h00;
        end else if (seq_ff == tcp_pkg::TCP_SEQ_EXEC && op_w == `TCP_OP_CMP &&
                     timer_ff[`TCP_CMP_MSB:0] == entry[`TCP_CMP_MSB:0]) begin
            outs_ff[entry[`TCP_SEL_MSB:`TCP_SEL_LSB]] <= entry[`TCP_ACT_BIT];
        end
    end
    assign timed_outputs = outs_ff;

    ////////////////////////////////////////////////////////////////////////////////
    property p_out_reset;
        @(posedge sys_clk) disable iff (!rst_n) $rose(rst_n) |-> (timed_outputs == 8'h00);
    endproperty
    a_out_reset: assert property (p_out_reset) else $error("outputs not low after reset");

    property p_tick_pulse;
        @(posedge sys_clk) disable iff (!rst_n) tick_ff |=> !tick_ff;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");

    property p_div2;
        @(posedge sys_clk) disable iff (!rst_n)
            (tick_ff && setup_ff[4:0] == 5'h10) ##1 (setup_ff[4:0] == 5'h10) |=> tick_ff;
    endproperty
    a_div2: assert property (p_div2) else $error("divide by two broken");

    property p_div16_quiet;
        @(posedge sys_clk) disable iff (!rst_n)
            (tick_ff && setup_ff[4:0] == 5'h00) |=> (!tick_ff)[*8];
    endproperty
    a_div16_quiet: assert property (p_div16_quiet) else $error("slow tick too early");

    property p_timer_inc;
        @(posedge sys_clk) disable iff (!rst_n) tick_ff |=> timer_ff == $past(timer_ff) + 20'h0_0001;
    endproperty
    a_timer_inc: assert property (p_timer_inc) else $error("timer did not step on tick");

    property p_image;
        @(posedge sys_clk) disable iff (!rst_n)
            tick_ff |=> (b_we && b_waddr == `TCP_IMG_WORD && b_wdata[19:0] == $past(timer_ff) + 20'h0_0001 &&
                         b_wdata[31:24] == evt_ff);
    endproperty
    a_image: assert property (p_image) else $error("image word not rewritten");

    property p_restart;
        @(posedge sys_clk) disable iff (!rst_n)
            (tick_ff && cmd_en) |=> (seq_ff == tcp_pkg::TCP_SEQ_FETCH && cur_ff == $past(start_idx) && n_ff == 5'h00);
    endproperty
    a_restart: assert property (p_restart) else $error("sequencer not restarted at entry zero");

    property p_ded_cap;
        @(posedge sys_clk) disable iff (!rst_n)
            (rise_w[0] && capen_ff[0]) |-> ##[1:3] (b_we && b_waddr == `TCP_DED_TOP && !buf_wr_w);
    endproperty
    a_ded_cap: assert property (p_ded_cap) else $error("dedicated capture not stored");

    property p_buf_wrap;
        @(posedge sys_clk) disable iff (!rst_n) (buf_wr_w && bufptr_ff == buf_bot) |=> bufptr_ff == $past(buf_top);
    endproperty
    a_buf_wrap: assert property (p_buf_wrap) else $error("buffer did not wrap");

    property p_mode_slot;
        @(posedge sys_clk) disable iff (!rst_n)
            buf_wr_w |-> (!mode_b || serve_w[3:2] == 2'b00) && serve_w[1:0] == 2'b00;
    endproperty
    a_mode_slot: assert property (p_mode_slot) else $error("dedicated input went to buffer");

    property p_pin_id;
        @(posedge sys_clk) disable iff (!rst_n) (b_we && !img_pend_ff) |-> $onehot0(b_wdata[23:20]);
    endproperty
    a_pin_id: assert property (p_pin_id) else $error("pin id not one-hot");

    property p_half_skip;
        @(posedge sys_clk) disable iff (!rst_n)
            (seq_ff == tcp_pkg::TCP_SEQ_FETCH && skip_w && !tick_ff) |=> seq_ff == tcp_pkg::TCP_SEQ_IDLE;
    endproperty
    a_half_skip: assert property (p_half_skip) else $error("half-rate entry ran on odd tick");

    c_slow_tick: cover property (@(posedge sys_clk) disable iff (!rst_n) tick_ff && !fast);
    c_buf_wrap: cover property (@(posedge sys_clk) disable iff (!rst_n) buf_wr_w && bufptr_ff == buf_bot);
    c_half_skip: cover property (@(posedge sys_clk) disable iff (!rst_n) seq_ff == tcp_pkg::TCP_SEQ_FETCH && skip_w);
    c_ded_cap: cover property (@(posedge sys_clk) disable iff (!rst_n) serve_w[3] && mode_b);
endmodule

/* tb/tcp_host.sv */
`timescale 1ns/1ps
module tcp_host (
    // clock
    input wire logic sys_clk,
    // requests to the device
    output logic [15:0] cpu_addr,
    output logic cpu_wr,
    output logic cpu_rd,
    output logic [7:0] cpu_wdata,
    // answers
    input wire logic [7:0] cpu_rdata,
    input wire logic cpu_rvalid
);
    initial begin
        cpu_addr = 16'h0000;
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        cpu_wdata = 8'h00;
    end
    // one-cycle strobe, changed only at the falling edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(negedge sys_clk);
        cpu_wr = 1'b0;
        // released data must not keep looking valid
        cpu_wdata = ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        int n;
        @(negedge sys_clk);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge sys_clk);
        cpu_rd = 1'b0;
        n = 0;
        while (cpu_rvalid !== 1'b1 && n < 8) begin
            @(negedge sys_clk);
            n++;
        end
        d = cpu_rdata;
    endtask
endmodule

/* tb/tb_timer_coprocessor_timebase_ram.sv */
`timescale 1ns/1ps
module tb_timer_coprocessor_timebase_ram;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] cap = 6'h00;
    logic [15:0] cpu_addr;
    logic cpu_wr;
    logic cpu_rd;
    logic cpu_rvalid;
    logic [7:0] cpu_wdata;
    logic [7:0] cpu_rdata;
    logic [7:0] timed_outputs;
    logic [7:0] v;
    logic [7:0] t0;
    logic [15:0] tgt;
    logic [15:0] te;
    logic [7:0] hw [16];
    int fails = 0;
    int checks = 0;
    int n;
    // register rows: address, byte written, byte read back
    logic [15:0] ra [7] = '{16'h1040, 16'h1041, 16'h1042, 16'h104D, 16'h104F, 16'h1044, 16'h0090};
    logic [7:0] rw [7] = '{8'h15, 8'h05, 8'h1A, 8'h3F, 8'h01, 8'hAA, 8'h5A};
    logic [7:0] re [7] = '{8'h15, 8'h05, 8'h1A, 8'h3F, 8'h01, 8'h00, 8'h5A};
    // prescaler rows: setup byte and the divide it gives
    logic [7:0] ps [7] = '{8'h10, 8'h11, 8'h13, 8'h1F, 8'h00, 8'h01, 8'h0F};
    int dv [7] = '{2, 2, 4, 16, 16, 16, 128};
    always #5 sys_clk = ~sys_clk;
    tcp_top #(.RAM_AT_HI(1'b0)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .cpu_addr(cpu_addr),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .cpu_rvalid(cpu_rvalid), .capture_in_1(cap[0]), .capture_in_2(cap[1]), .capture_in_3(cap[2]),
        .capture_in_4(cap[3]), .capture_in_5(cap[4]), .capture_in_6_event(cap[5]),
        .timed_outputs(timed_outputs));
    tcp_host host (.sys_clk(sys_clk), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
        .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // pins pass a synchroniser, so pulses are long and spaced
    task automatic pulse(input int i);
        @(negedge sys_clk);
        cap[i] = 1'b1;
        repeat (10) @(negedge sys_clk);
        cap[i] = 1'b0;
        repeat (20) @(negedge sys_clk);
    endtask
    task automatic finish_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #600000;
        fails++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge sys_clk);
        chk(timed_outputs, 8'h00);
        rst_n = 1'b1;
        host.rd(16'h1043, v);
        chk(v, 8'h70);
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            host.wr(ra[i], rw[i]);
            host.rd(ra[i], v);
            chk(v, re[i]);
        end
        host.wr(16'h104D, 8'h00);
        host.wr(16'h104F, 8'h00);
        $display("test registers done");
        // equal spacing of two image reads spans exactly eight ticks
        for (int i = 0; i < 7; i++) begin
            host.wr(16'h1040, ps[i]);
            repeat (2 * dv[i] + 4) @(negedge sys_clk);
            host.rd(16'h00FF, t0);
            repeat (8 * dv[i] - 3) @(negedge sys_clk);
            host.rd(16'h00FF, v);
            chk(v - t0, 8'h08);
        end
        $display("test prescaler done");
        // one compare entry at word 24: two slots, inside the budget of 16
        host.wr(16'h1040, 8'h1F);
        host.wr(16'h1041, 8'h08);
        host.wr(16'h1042, 8'h18);
        host.rd(16'h00FE, tgt[15:8]);
        host.rd(16'h00FF, tgt[7:0]);
        tgt = tgt + 16'h0028;
        host.wr(16'h00E0, 8'h10);
        host.wr(16'h00E1, 8'h0A);
        host.wr(16'h00E2, tgt[15:8]);
        host.wr(16'h00E3, tgt[7:0]);
        host.wr(16'h1040, 8'h3F);
        chk(timed_outputs, 8'h00);
        n = 0;
        while (timed_outputs[2] !== 1'b1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        chk(timed_outputs, 8'h04);
        $display("test compare done");
        // halving entry first, then one full-rate and two half-rate compares; timer parity is tick parity
        host.wr(16'h1040, 8'h1F);
        host.rd(16'h00FE, tgt[15:8]);
        host.rd(16'h00FF, tgt[7:0]);
        tgt = (tgt + 16'h0028) | 16'h0001;
        te = tgt + 16'h0001;
        hw = '{8'h10, 8'h0E, te[15:8], te[7:0], 8'h10, 8'h0B, tgt[15:8], tgt[7:0],
            8'h10, 8'h0D, tgt[15:8], tgt[7:0], 8'hF0, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 16; i++) begin
            host.wr(16'h00D4 + 16'(i), hw[i]);
        end
        host.wr(16'h1042, 8'h15);
        host.wr(16'h1040, 8'h3F);
        n = 0;
        while (timed_outputs[6] !== 1'b1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        repeat (40) @(negedge sys_clk);
        chk(timed_outputs, 8'h64);
        $display("test halving done");
        host.wr(16'h104D, 8'h05);
        pulse(5);
        pulse(5);
        pulse(0);
        pulse(2);
        host.rd(16'h00F8, v);
        chk(v, 8'h02);
        host.rd(16'h00F9, v);
        chk(v & 8'hF0, 8'h00);
        host.rd(16'h00F0, v);
        chk(v, 8'h02);
        host.rd(16'h00F1, v);
        chk(v & 8'hF0, 8'h10);
        host.rd(16'h1043, v);
        chk(v, 8'h6C);
        repeat (3) pulse(2);
        host.rd(16'h1043, v);
        chk(v, 8'h70);
        $display("test capture done");
        host.wr(16'h104F, 8'h01);
        host.wr(16'h00F0, 8'h00);
        pulse(2);
        host.rd(16'h1043, v);
        chk(v, 8'h70);
        host.rd(16'h00F0, v);
        chk(v, 8'h02);
        $display("test mode b done");
        finish_test();
    end
endmodule
